// ==== pkg/fan_temp_pkg.sv ====
// Package for the fan temperature threshold register bank
package fan_temp_pkg;
  localparam logic [7:0] ADDR_R1_START = 8'h67;
  localparam logic [7:0] ADDR_LOC_START = 8'h68;
  localparam logic [7:0] ADDR_R2_START = 8'h69;
  localparam logic [7:0] ADDR_R1_CRIT = 8'h6a;
  localparam logic [7:0] ADDR_LOC_CRIT = 8'h6b;
  localparam logic [7:0] ADDR_R2_CRIT = 8'h6c;
  localparam logic [7:0] ADDR_R1_LOC_HYST = 8'h6d;
  localparam logic [7:0] ADDR_R2_HYST = 8'h6e;
  localparam logic [7:0] ADDR_XOR_TEST = 8'h6f;
  localparam logic [7:0] ADDR_R1_OFFSET = 8'h70;
  localparam logic [7:0] ADDR_LOC_OFFSET = 8'h71;
  localparam logic [7:0] ADDR_R2_OFFSET = 8'h72;
  localparam logic [7:0] ADDR_STATUS = 8'h7a;
  localparam logic [7:0] RST_START = 8'h5a;
  localparam logic [7:0] RST_CRIT = 8'h64;
  localparam logic [7:0] RST_R1_LOC_HYST = 8'h44;
  localparam logic [7:0] RST_R2_HYST = 8'h40;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] CRIT_DISABLE = 8'h80;
  localparam logic [7:0] CRIT_RELEASE_DEG = 8'h04;
  localparam int XOR_TEST_BIT = 0;
  localparam int NUM_CH = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0][7:0] start;
    logic [2:0][7:0] crit;
    logic [7:0] hyst_r1_loc;
    logic [7:0] hyst_r2;
    logic [7:0] xor_test;
    logic [2:0][7:0] offset;
    logic [2:0][9:0] corr_temp;
    logic [2:0] fan_on;
    logic [2:0] crit_hit;
    logic [7:0] rdata;
  } bank_state_t;
endpackage : fan_temp_pkg

// ==== src/fan_temp_threshold_regs.sv ====
// Fan start, critical limit, hysteresis and offset register bank
// Operation
// R1 - Above its start threshold a channel's fan runs at minimum duty, ramping by span
// R2 - Any channel above its critical limit forces every PWM output to full duty
// R3 - A critical limit of 0x80 disables the failsafe for that channel
// R4 - Failsafe holds until temperature falls four degrees below the limit
// R5 - Below start, fan stays at minimum until threshold minus hysteresis is reached
// R6 - Hysteresis fields are four bits, zero to fifteen whole degrees
// R7 - Software should program at least four degrees of hysteresis
// R8 - Hysteresis registers: remote1 and local share one, remote2 has one
// R9 - Bit 0 of the test register enables XOR-tree test mode
// R10 - Software must not write the upper seven test register bits
// R11 - Local offset, signed quarter-degree steps, is added to local reading
// R12 - Each remote channel has its own signed quarter-degree offset
// R13 - While lock is set, all these registers ignore writes
// R14 - Start thresholds reset to 0x5a, critical limits to 0x64
// R15 - Comparisons use offset-corrected temperature, updated per completed measurement
// R16 - Failsafe overrides every fan control mode while engaged
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module fan_temp_threshold_regs #(
  parameter int CH = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic config_lock,
  input wire logic [CH-1:0][9:0] meas_temp,
  input wire logic [CH-1:0] meas_done,
  output logic [CH-1:0][9:0] corrected_temp,
  output logic [CH-1:0] fan_min_run,
  output logic [CH-1:0][7:0] fan_start_threshold,
  output logic failsafe_full_duty,
  output logic xor_test_enable
);

  fan_temp_pkg::bank_state_t st;
  fan_temp_pkg::bank_state_t next_st;
  fan_temp_pkg::reg_req_t req;

  // Temperatures are 10-bit signed, quarter degrees (8.2 format)
  function automatic logic [9:0] add_offset(input logic [9:0] t, input logic [7:0] o);
    add_offset = t + {{2{o[7]}}, o};
  endfunction : add_offset

  function automatic logic signed [10:0] deg_q(input logic [7:0] d);
    deg_q = {d[7], d, 2'b00};
  endfunction : deg_q

  function automatic logic [3:0] hyst_of(input fan_temp_pkg::bank_state_t s, input int c);
    if (c == 0) begin
      hyst_of = s.hyst_r1_loc[7:4];
    end else if (c == 1) begin
      hyst_of = s.hyst_r1_loc[3:0];
    end else begin
      hyst_of = s.hyst_r2[7:4];
    end
  endfunction : hyst_of

  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr & ~config_lock; // [R13]
  assign req.rd = reg_rd;

  always_comb begin
    logic signed [10:0] t;
    logic signed [10:0] lim;
    t = '0;
    lim = '0;
    next_st = st;
    // Register writes
    if (req.wr) begin
      if (req.addr == fan_temp_pkg::ADDR_R1_START) begin
        next_st.start[0] = req.wdata;
      end else if (req.addr == fan_temp_pkg::ADDR_LOC_START) begin
        next_st.start[1] = req.wdata;
      end else if (req.addr == fan_temp_pkg::ADDR_R2_START) begin
        next_st.start[2] = req.wdata;
      end else if (req.addr == fan_temp_pkg::ADDR_R1_CRIT) begin
        next_st.crit[0] = req.wdata;
      end else if (req.addr == fan_temp_pkg::ADDR_LOC_CRIT) begin
        next_st.crit[1] = req.wdata;
      end else if (req.addr == fan_temp_pkg::ADDR_R2_CRIT) begin
        next_st.crit[2] = req.wdata;
      end else if (req.addr == fan_temp_pkg::ADDR_R1_LOC_HYST) begin
        next_st.hyst_r1_loc = req.wdata; // [R8]
      end else if (req.addr == fan_temp_pkg::ADDR_R2_HYST) begin
        next_st.hyst_r2 = {req.wdata[7:4], 4'h0}; // [R8]
      end else if (req.addr == fan_temp_pkg::ADDR_XOR_TEST) begin
        // Upper bits are not stored, so a stray write cannot disturb anything
        next_st.xor_test = {7'h00, req.wdata[fan_temp_pkg::XOR_TEST_BIT]}; // [R9] [R10]
      end else if (req.addr == fan_temp_pkg::ADDR_R1_OFFSET) begin
        next_st.offset[0] = req.wdata; // [R12]
      end else if (req.addr == fan_temp_pkg::ADDR_LOC_OFFSET) begin
        next_st.offset[1] = req.wdata; // [R11]
      end else if (req.addr == fan_temp_pkg::ADDR_R2_OFFSET) begin
        next_st.offset[2] = req.wdata; // [R12]
      end
    end
    // Comparisons use the corrected value held since the last completed measurement
    for (int c = 0; c < CH; c++) begin
      if (meas_done[c]) begin
        next_st.corr_temp[c] = add_offset(meas_temp[c], st.offset[c]); // [R11] [R12] [R15]
      end
      t = {st.corr_temp[c][9], st.corr_temp[c]};
      lim = deg_q(st.start[c]);
      if (t > lim) begin
        next_st.fan_on[c] = 1'b1; // [R1]
      end else if (t <= lim - $signed({5'b00000, hyst_of(st, c), 2'b00})) begin
        next_st.fan_on[c] = 1'b0; // [R5] [R6]
      end
      lim = deg_q(st.crit[c]);
      if (st.crit[c] == fan_temp_pkg::CRIT_DISABLE) begin
        next_st.crit_hit[c] = 1'b0; // [R3]
      end else if (t > lim) begin
        next_st.crit_hit[c] = 1'b1; // [R2]
      end else if (t < lim - deg_q(fan_temp_pkg::CRIT_RELEASE_DEG)) begin
        next_st.crit_hit[c] = 1'b0; // [R4]
      end
    end
    // Register reads, data valid the cycle after the strobe
    next_st.rdata = 8'h00;
    if (req.rd) begin
      if (req.addr == fan_temp_pkg::ADDR_R1_START) begin
        next_st.rdata = st.start[0];
      end else if (req.addr == fan_temp_pkg::ADDR_LOC_START) begin
        next_st.rdata = st.start[1];
      end else if (req.addr == fan_temp_pkg::ADDR_R2_START) begin
        next_st.rdata = st.start[2];
      end else if (req.addr == fan_temp_pkg::ADDR_R1_CRIT) begin
        next_st.rdata = st.crit[0];
      end else if (req.addr == fan_temp_pkg::ADDR_LOC_CRIT) begin
        next_st.rdata = st.crit[1];
      end else if (req.addr == fan_temp_pkg::ADDR_R2_CRIT) begin
        next_st.rdata = st.crit[2];
      end else if (req.addr == fan_temp_pkg::ADDR_R1_LOC_HYST) begin
        next_st.rdata = st.hyst_r1_loc;
      end else if (req.addr == fan_temp_pkg::ADDR_R2_HYST) begin
        next_st.rdata = st.hyst_r2;
      end else if (req.addr == fan_temp_pkg::ADDR_XOR_TEST) begin
        next_st.rdata = st.xor_test;
      end else if (req.addr == fan_temp_pkg::ADDR_R1_OFFSET) begin
        next_st.rdata = st.offset[0];
      end else if (req.addr == fan_temp_pkg::ADDR_LOC_OFFSET) begin
        next_st.rdata = st.offset[1];
      end else if (req.addr == fan_temp_pkg::ADDR_R2_OFFSET) begin
        next_st.rdata = st.offset[2];
      end else if (req.addr == fan_temp_pkg::ADDR_STATUS) begin
        next_st.rdata = {1'b0, st.crit_hit, 1'b0, st.fan_on};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.start <= {3{fan_temp_pkg::RST_START}}; // [R14]
      st.crit <= {3{fan_temp_pkg::RST_CRIT}}; // [R14]
      st.hyst_r1_loc <= fan_temp_pkg::RST_R1_LOC_HYST;
      st.hyst_r2 <= fan_temp_pkg::RST_R2_HYST;
      st.xor_test <= fan_temp_pkg::RST_ZERO;
      st.offset <= {3{fan_temp_pkg::RST_ZERO}};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign corrected_temp = st.corr_temp;
  assign fan_min_run = st.fan_on;
  assign fan_start_threshold = st.start;
  // Downstream duty logic must OR this over manual and ramp-limited duty
  assign failsafe_full_duty = |st.crit_hit; // [R16]
  assign xor_test_enable = st.xor_test[fan_temp_pkg::XOR_TEST_BIT]; // [R9]

  a_lock_blocks_write: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    reg_wr && config_lock && reg_addr == fan_temp_pkg::ADDR_R1_START |=> $stable(st.start[0]))
    else $error("start threshold changed while locked");
  a_crit_disable: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    st.crit[0] == fan_temp_pkg::CRIT_DISABLE |=> !st.crit_hit[0])
    else $error("failsafe active on disabled channel");
  a_failsafe_any: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    st.crit_hit != 3'b000 |-> failsafe_full_duty)
    else $error("failsafe not driven");
  a_crit_set: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    st.crit[1] != fan_temp_pkg::CRIT_DISABLE
    && $signed({st.corr_temp[1][9], st.corr_temp[1]}) > deg_q(st.crit[1])
    && !(reg_wr && !config_lock) |=> st.crit_hit[1])
    else $error("failsafe not set above limit");
  a_crit_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    st.crit_hit[1] && st.crit[1] != fan_temp_pkg::CRIT_DISABLE
    && $signed({st.corr_temp[1][9], st.corr_temp[1]}) >= deg_q(st.crit[1]) - 11'sd16
    |=> st.crit_hit[1])
    else $error("failsafe released early");
  a_offset_add: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    meas_done[1] && !(reg_wr && !config_lock)
    |=> corrected_temp[1] == $past(meas_temp[1]) + {{2{st.offset[1][7]}}, st.offset[1]})
    else $error("local offset not applied");
  a_fan_start: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    $signed({st.corr_temp[0][9], st.corr_temp[0]}) > deg_q(st.start[0]) |=> fan_min_run[0])
    else $error("fan not started above threshold");
  a_read_data: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    reg_rd && reg_addr == fan_temp_pkg::ADDR_XOR_TEST |=> reg_rdata == {7'h00, xor_test_enable})
    else $error("test register readback wrong");

  // Write steps shared by the lock and write checks below
  sequence s_open_write(logic [7:0] a);
    reg_wr && !config_lock && reg_addr == a;
  endsequence

  sequence s_locked_write(logic [7:0] a);
    reg_wr && config_lock && reg_addr == a;
  endsequence

  a_lock_loc_start: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_LOC_START)
    |=> $stable(st.start[1]))
    else $error("local start threshold changed while locked");

  a_lock_r2_start: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_R2_START)
    |=> $stable(st.start[2]))
    else $error("remote2 start threshold changed while locked");

  a_lock_r1_crit: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_R1_CRIT)
    |=> $stable(st.crit[0]))
    else $error("remote1 limit changed while locked");

  a_lock_loc_crit: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_LOC_CRIT)
    |=> $stable(st.crit[1]))
    else $error("local limit changed while locked");

  a_lock_r2_crit: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_R2_CRIT)
    |=> $stable(st.crit[2]))
    else $error("remote2 limit changed while locked");

  a_lock_hyst_pair: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_R1_LOC_HYST)
    |=> $stable(st.hyst_r1_loc))
    else $error("shared hysteresis changed while locked");

  a_lock_hyst_r2: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_R2_HYST)
    |=> $stable(st.hyst_r2))
    else $error("remote2 hysteresis changed while locked");

  a_lock_xor_test: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_XOR_TEST)
    |=> $stable(st.xor_test))
    else $error("test register changed while locked");

  a_lock_r1_offset: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_R1_OFFSET)
    |=> $stable(st.offset[0]))
    else $error("remote1 offset changed while locked");

  a_lock_loc_offset: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_LOC_OFFSET)
    |=> $stable(st.offset[1]))
    else $error("local offset changed while locked");

  a_lock_r2_offset: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    s_locked_write(fan_temp_pkg::ADDR_R2_OFFSET)
    |=> $stable(st.offset[2]))
    else $error("remote2 offset changed while locked");

  a_write_r1_start: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    s_open_write(fan_temp_pkg::ADDR_R1_START)
    |=> st.start[0] == $past(reg_wdata))
    else $error("remote1 start threshold write lost");

  a_write_loc_start: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    s_open_write(fan_temp_pkg::ADDR_LOC_START)
    |=> st.start[1] == $past(reg_wdata))
    else $error("local start threshold write lost");

  a_write_r2_start: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    s_open_write(fan_temp_pkg::ADDR_R2_START)
    |=> st.start[2] == $past(reg_wdata))
    else $error("remote2 start threshold write lost");

  a_write_r1_crit: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    s_open_write(fan_temp_pkg::ADDR_R1_CRIT)
    |=> st.crit[0] == $past(reg_wdata))
    else $error("remote1 limit write lost");

  a_write_loc_crit: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    s_open_write(fan_temp_pkg::ADDR_LOC_CRIT)
    |=> st.crit[1] == $past(reg_wdata))
    else $error("local limit write lost");

  a_write_r2_crit: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    s_open_write(fan_temp_pkg::ADDR_R2_CRIT)
    |=> st.crit[2] == $past(reg_wdata))
    else $error("remote2 limit write lost");

  a_write_hyst_pair: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    s_open_write(fan_temp_pkg::ADDR_R1_LOC_HYST)
    |=> st.hyst_r1_loc == $past(reg_wdata))
    else $error("shared hysteresis write lost");

  a_write_hyst_r2: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    s_open_write(fan_temp_pkg::ADDR_R2_HYST)
    |=> st.hyst_r2 == {$past(reg_wdata[7:4]), 4'h0})
    else $error("remote2 hysteresis write lost");

  a_write_xor_test: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    s_open_write(fan_temp_pkg::ADDR_XOR_TEST)
    |=> st.xor_test == {7'h00, $past(reg_wdata[0])})
    else $error("test enable write lost");

  a_write_r1_offset: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    s_open_write(fan_temp_pkg::ADDR_R1_OFFSET)
    |=> st.offset[0] == $past(reg_wdata))
    else $error("remote1 offset write lost");

  a_write_loc_offset: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    s_open_write(fan_temp_pkg::ADDR_LOC_OFFSET)
    |=> st.offset[1] == $past(reg_wdata))
    else $error("local offset write lost");

  a_write_r2_offset: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    s_open_write(fan_temp_pkg::ADDR_R2_OFFSET)
    |=> st.offset[2] == $past(reg_wdata))
    else $error("remote2 offset write lost");

  // Hysteresis band: a running fan keeps running until threshold minus hysteresis
  a_fan_hold_r1: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    st.fan_on[0] && $signed({st.corr_temp[0][9], st.corr_temp[0]})
    > deg_q(st.start[0]) - $signed({5'b00000, hyst_of(st, 0), 2'b00}) |=> fan_min_run[0])
    else $error("remote1 fan stopped inside hysteresis");

  a_fan_hold_loc: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    st.fan_on[1] && $signed({st.corr_temp[1][9], st.corr_temp[1]})
    > deg_q(st.start[1]) - $signed({5'b00000, hyst_of(st, 1), 2'b00}) |=> fan_min_run[1])
    else $error("local fan stopped inside hysteresis");

  a_fan_hold_r2: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    st.fan_on[2] && $signed({st.corr_temp[2][9], st.corr_temp[2]})
    > deg_q(st.start[2]) - $signed({5'b00000, hyst_of(st, 2), 2'b00}) |=> fan_min_run[2])
    else $error("remote2 fan stopped inside hysteresis");

  a_fan_start_loc: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    $signed({st.corr_temp[1][9], st.corr_temp[1]}) > deg_q(st.start[1])
    |=> fan_min_run[1])
    else $error("local fan not started above threshold");

  a_fan_start_r2: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    $signed({st.corr_temp[2][9], st.corr_temp[2]}) > deg_q(st.start[2])
    |=> fan_min_run[2])
    else $error("remote2 fan not started above threshold");

  a_crit_set_r1: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    st.crit[0] != fan_temp_pkg::CRIT_DISABLE
    && $signed({st.corr_temp[0][9], st.corr_temp[0]}) > deg_q(st.crit[0]) |=> st.crit_hit[0])
    else $error("remote1 failsafe not set above limit");

  a_crit_hold_r1: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    st.crit_hit[0] && st.crit[0] != fan_temp_pkg::CRIT_DISABLE
    && $signed({st.corr_temp[0][9], st.corr_temp[0]}) >= deg_q(st.crit[0]) - 11'sd16
    |=> st.crit_hit[0])
    else $error("remote1 failsafe released early");

  a_crit_clear_loc: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    st.crit_hit[1] && $signed({st.corr_temp[1][9], st.corr_temp[1]})
    < deg_q(st.crit[1]) - 11'sd16 |=> !st.crit_hit[1])
    else $error("local failsafe not released below band");

  a_crit_clear_r1: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    st.crit_hit[0] && $signed({st.corr_temp[0][9], st.corr_temp[0]})
    < deg_q(st.crit[0]) - 11'sd16 |=> !st.crit_hit[0])
    else $error("remote1 failsafe not released below band");

  a_crit_disable_r2: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    st.crit[2] == fan_temp_pkg::CRIT_DISABLE
    |=> !st.crit_hit[2])
    else $error("failsafe active on disabled remote2 channel");

  a_offset_r1: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    meas_done[0] && !(reg_wr && !config_lock)
    |=> corrected_temp[0] == $past(meas_temp[0]) + {{2{st.offset[0][7]}}, st.offset[0]})
    else $error("remote1 offset not applied");

  a_offset_r2: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    meas_done[2] && !(reg_wr && !config_lock)
    |=> corrected_temp[2] == $past(meas_temp[2]) + {{2{st.offset[2][7]}}, st.offset[2]})
    else $error("remote2 offset not applied");
endmodule : fan_temp_threshold_regs
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the fan temperature threshold register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, config_lock = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0][9:0] meas_temp = '0, corrected_temp;
  logic [2:0] meas_done = 3'h0, fan_min_run;
  logic [2:0][7:0] fan_start_threshold;
  logic failsafe_full_duty, xor_test_enable;
  int mismatches = 0, check_count = 0, cycles = 0;
  int m[12] = '{8'h5a, 8'h5a, 8'h5a, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 0, 0, 0, 0};
  int fan[3] = '{0, 0, 0}, fs[3] = '{0, 0, 0};
  always #20 clk = ~clk;
  fan_temp_threshold_regs #(.CH(3)) fan_temp_threshold_regs_i (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .config_lock(config_lock), .meas_temp(meas_temp),
    .meas_done(meas_done), .corrected_temp(corrected_temp), .fan_min_run(fan_min_run),
    .fan_start_threshold(fan_start_threshold), .failsafe_full_duty(failsafe_full_duty),
    .xor_test_enable(xor_test_enable));
  // A hang counts as a mismatch and still reaches the single verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  function automatic int stat();
    return fs[2] * 64 + fs[1] * 32 + fs[0] * 16 + fan[2] * 4 + fan[1] * 2 + fan[0];
  endfunction : stat
  function automatic int sgn(input int v);
    return (v > 127) ? v - 256 : v;
  endfunction : sgn
  task automatic chk(input string n, input logic [9:0] got, input int e);
    check_count++;
    if (got !== 10'(e)) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", n, e, got);
    end
  endtask : chk
  // Upper test bits are not stored and the unused hysteresis nibble reads zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (!config_lock && a >= 8'h67 && a <= 8'h72)
      m[a - 8'h67] = d & ((a == 8'h6f) ? 8'h01 : (a == 8'h6e) ? 8'hf0 : 8'hff);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {2'b00, reg_rdata},
      (a == 8'h7a) ? stat() : (a >= 8'h67 && a <= 8'h72) ? m[a - 8'h67] : 0);
  endtask : rd
  task automatic rd_all();
    for (int a = 8'h67; a <= 8'h72; a++) rd(8'(a));
    rd(8'h50);
    for (int c = 0; c < 3; c++) chk("threshold", {2'b00, fan_start_threshold[c]}, m[c]);
    chk("xor_test_enable", {9'h000, xor_test_enable}, m[8]);
  endtask : rd_all
  // All temperatures are whole degrees so the degree comparison has no rounding doubt
  task automatic meas(input int d0, input int d1, input int d2);
    int dg[3], cr[3], h, lim;
    dg = '{d0, d1, d2};
    @(posedge clk);
    for (int c = 0; c < 3; c++) begin
      meas_temp[c] <= 10'(dg[c] * 4);
      cr[c] = dg[c] * 4 + sgn(m[9 + c]);
      h = (c == 0) ? m[6] >> 4 : (c == 1) ? m[6] & 15 : m[7] >> 4;
      lim = sgn(m[3 + c]);
      if (cr[c] / 4 > sgn(m[c])) fan[c] = 1;
      else if (cr[c] / 4 <= sgn(m[c]) - h) fan[c] = 0;
      if (m[3 + c] == 8'h80) fs[c] = 0;
      else if (cr[c] / 4 > lim) fs[c] = 1;
      else if (cr[c] / 4 < lim - 4) fs[c] = 0;
    end
    meas_done <= 3'h7;
    @(posedge clk);
    meas_done <= 3'h0;
    @(posedge clk);
    #1;
    for (int c = 0; c < 3; c++) chk("corrected_temp", corrected_temp[c], cr[c]);
    @(posedge clk);
    #1;
    for (int c = 0; c < 3; c++) chk("fan_min_run", {9'h000, fan_min_run[c]}, fan[c]);
    chk("failsafe", {9'h000, failsafe_full_duty}, fs[0] | fs[1] | fs[2]);
    rd(8'h7a);
  endtask : meas
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(2162));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_all();
    $display("reset values done");
    wr(8'h6f, 8'h01);
    rd_all();
    wr(8'h6f, 8'h00);
    for (int a = 8'h67; a <= 8'h72; a++) wr(8'(a), 8'($urandom) & ((a == 8'h6f) ? 8'h01 : 8'hff));
    rd_all();
    $display("write readback done");
    @(posedge clk);
    config_lock <= 1'b1;
    for (int a = 8'h67; a <= 8'h72; a++) wr(8'(a), 8'($urandom) & ((a == 8'h6f) ? 8'h01 : 8'hff));
    rd_all();
    config_lock <= 1'b0;
    $display("lock done");
    for (int c = 0; c < 3; c++) wr(8'(8'h67 + c), 8'h5a);
    wr(8'h6a, 8'h64);
    wr(8'h6b, 8'h5f);
    wr(8'h6c, 8'h80);
    wr(8'h6d, 8'({4'(4 + $urandom % 12), 4'(4 + $urandom % 12)}));
    wr(8'h6e, 8'({4'(4 + $urandom % 12), 4'(4 + $urandom % 12)}));
    for (int c = 0; c < 3; c++) wr(8'(8'h70 + c), 8'((int'($urandom % 9) - 4) * 4));
    for (int i = 0; i < 60; i++)
      meas(80 + $urandom % 35, 80 + $urandom % 35, 80 + $urandom % 35);
    $display("temperature sweep done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
